// ==== hw/ldp_defs.svh ====
/*
  Constants of the LED dimming PWM block: register offsets, field positions,
  reset values and counter widths.
  Assumes it is included by bare name from hw/ files only.
*/
`ifndef LDP_DEFS_SVH
`define LDP_DEFS_SVH

// measurement counter width; 22 bits covers a 60 Hz input at 100 MHz
`define LDP_CNT_W        22
`define LDP_CNT_MAX      22'h3F_FFFF

// dimming period is 1024 steps, 90 degrees is a quarter of that
`define LDP_STEP_W       10
`define LDP_DUTY_W       11
`define LDP_DUTY_FULL    11'h400
`define LDP_PHASE_STEP   10'h100
`define LDP_DIV_STEPS    4'hA
`define LDP_CODE_W       8
`define LDP_NUM_CH       4
`define LDP_NUM_SYNC     6

// register indices; bus addresses 4'h0, 4'h4, 4'h8 and 4'hC map to the first four
`define LDP_REG_CTRL     4'h0
`define LDP_REG_PERIOD   4'h1
`define LDP_REG_FRAME    4'h2
`define LDP_REG_STATUS   4'h3
`define LDP_REG_LEVEL    4'h4
`define LDP_REG_NONE     4'hF

// control fields
`define LDP_CTRL_ENABLE  0
`define LDP_CTRL_FLOCK   1

// status fields
`define LDP_ST_DIRECT    16
`define LDP_ST_ANALOG    17
`define LDP_ST_LEVEL     18
`define LDP_ST_PSHIFT    19
`define LDP_ST_VALID     20

// reset values
`define LDP_RST_ENABLE   1'b0
`define LDP_RST_FLOCK    1'b0
`define LDP_RST_PERIOD   16'h0061
`define LDP_RST_FSHIFT   3'h0

`endif

// ==== hw/ldp_pkg.sv ====
/*
  Types of the LED dimming PWM block: measurement state and the packed
  state record of the top module.
  Assumes ldp_defs.svh is on the include path.
*/
`include "ldp_defs.svh"
`default_nettype none

package ldp_pkg;

  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_DIV
  } ldp_meas_type;

  typedef struct packed {
    logic                     pwmPrev;
    logic                     frmPrev;
    ldp_meas_type             meas;
    logic [`LDP_CNT_W-1:0]    highCnt;
    logic [`LDP_CNT_W-1:0]    perCnt;
    logic [`LDP_CNT_W:0]      divRem;
    logic [`LDP_CNT_W-1:0]    divDen;
    logic [`LDP_STEP_W-1:0]   divQ;
    logic [3:0]               divBits;
    logic [`LDP_DUTY_W-1:0]   dutyMeas;
    logic                     measValid;
    logic [15:0]              preCnt;
    logic [`LDP_STEP_W-1:0]   stepCnt;
    logic [`LDP_CNT_W-1:0]    frameCnt;
    logic [`LDP_CNT_W-1:0]    frameLen;
    logic [`LDP_DUTY_W-1:0]   effDuty;
    logic                     levelSel;
    logic [`LDP_NUM_CH-1:0]   gate;
    logic                     levelOut;
    logic                     ctrlEnable;
    logic                     ctrlFrameLock;
    logic [15:0]              periodReg;
    logic [2:0]               frameShift;
    logic                     ack;
    logic [31:0]              rdata;
  } ldp_state_type;

endpackage : ldp_pkg

`default_nettype wire

// ==== hw/ldp_sync.sv ====
/*
  Two-flop synchroniser for a bundle of independent level inputs.
  Assumes each bit is a slow level; multi-bit values are not coherent.
*/
`default_nettype none

module ldp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // asynchronous levels in, synchronous levels out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;

endmodule // ldp_sync

`default_nettype wire

// ==== hw/ldp_dimming.sv ====
/*
  LED dimming PWM controller: direct pass-through or decoded 10-bit duty
  regenerated at an internal or frame-locked rate, optional analog scaling,
  90 degree phase shift and two-level current select, plus an Avalon-MM
  register slave.
  Assumes pins arrive asynchronously, the analog code comes from a converter
  clocked by sys_clk, and the bus master follows Avalon-MM with waitrequest.
*/
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
// Functional notes
// - select 0 uses primary, 1 secondary current
// - select change: immediate direct, else next period
// - strapped direct mode copies input exactly
// - otherwise measure 10-bit duty, regenerate it
// - analog level arrives as 8-bit duty code
// - analog mode only while analog enable high
// - analog duty is measured duty times code
// - rate from internal oscillator or frame lock
// - phase shift outside direct mode, sequential
// - result gates all four channels, peak current
// - each channel delayed ninety degrees further
`include "ldp_defs.svh"
`default_nettype none

module ldp_dimming (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // avalon-mm register slave
  input  wire logic [3:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic      [31:0]            readdata,
  output logic                        waitrequest,
  // dimming pins
  input  wire logic                   dimming_pwm_input,
  input  wire logic                   current_level_select,
  input  wire logic                   analog_dimming_enable,
  input  wire logic                   phase_shift_enable,
  input  wire logic                   frame_sync_input,
  input  wire logic                   directModeStrap,
  // analog level code from the converter, same clock
  input  wire logic [`LDP_CODE_W-1:0] analogLevelCode,
  // channel gates and current level
  output logic      [`LDP_NUM_CH-1:0] channelGate,
  output logic                        currentSetSecondary
);

  ldp_pkg::ldp_state_type st_ff;
  ldp_pkg::ldp_state_type nxt_st;

  logic [`LDP_NUM_SYNC-1:0] pinSync;
  logic                     pwmSync;
  logic                     cselSync;
  logic                     adimSync;
  logic                     psSync;
  logic                     frmSync;
  logic                     directSync;

  ldp_sync #(
    .WIDTH (`LDP_NUM_SYNC)
  ) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .asyncIn ({directModeStrap, frame_sync_input, phase_shift_enable,
               analog_dimming_enable, current_level_select, dimming_pwm_input}),
    .syncOut (pinSync)
  );

  assign pwmSync    = pinSync[0];
  assign cselSync   = pinSync[1];
  assign adimSync   = pinSync[2];
  assign psSync     = pinSync[3];
  assign frmSync    = pinSync[4];
  assign directSync = pinSync[5];

  // decodes a word address into a register index, shared by read and write
  function automatic logic [3:0] regIndex(input logic [3:0] addr);
    logic [3:0] idx;
    idx = `LDP_REG_NONE;
    case (addr)
      4'h0:    idx = `LDP_REG_CTRL;
      4'h4:    idx = `LDP_REG_PERIOD;
      4'h8:    idx = `LDP_REG_FRAME;
      4'hC:    idx = `LDP_REG_STATUS;
      default: idx = `LDP_REG_NONE;
    endcase
    return idx;
  endfunction

  // byte-lane merge for writable registers
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  // quarter-period offset of one channel; zero for all while phase shift is off
  function automatic logic [`LDP_STEP_W-1:0] phaseOffset(input int   chan,
                                                         input logic shiftOn);
    logic [`LDP_STEP_W-1:0] off;
    off = '0;
    if (shiftOn) begin
      off = `LDP_STEP_W'(chan * `LDP_PHASE_STEP);
    end
    return off;
  endfunction

  // code 255 counts as full scale so that 100% times 100% stays 100%,
  // traded for a double-size step from code 127 to code 128
  function automatic logic [`LDP_DUTY_W-1:0] scaleDuty(input logic [`LDP_DUTY_W-1:0] duty,
                                                       input logic [`LDP_CODE_W-1:0] code);
    logic [19:0] prod;
    prod = 20'(duty) * 20'({1'b0, code} + 9'(code[`LDP_CODE_W-1]));
    return prod[18:8];
  endfunction

  logic [3:0]  wordIdx;
  logic        direct;
  logic        analogMode;
  logic        frameEdge;
  logic        pwmRise;
  logic        tick;
  logic        periodStart;
  logic [15:0] reload;
  logic [`LDP_CNT_W-1:0]   frameScaled;
  logic [`LDP_CNT_W:0]     divTrial;
  logic [`LDP_DUTY_W-1:0]  targetDuty;
  logic [`LDP_NUM_CH-1:0]  chanOn;
  logic [31:0]             regValue;
  logic [31:0]             ctrlWord;
  logic [31:0]             merged;

  assign wordIdx    = regIndex(address);
  assign direct     = directSync;
  assign analogMode = adimSync & ~directSync;
  assign pwmRise    = pwmSync & ~st_ff.pwmPrev;
  assign frameEdge  = frmSync & ~st_ff.frmPrev & st_ff.ctrlFrameLock;

  // frame-locked rate: 1024 steps per frame divided by 2^shift periods
  assign frameScaled = st_ff.frameLen >> (`LDP_STEP_W + st_ff.frameShift);
  assign reload      = st_ff.ctrlFrameLock ? frameScaled[15:0]
                                           : st_ff.periodReg;
  assign tick        = (st_ff.preCnt >= reload);
  assign periodStart = frameEdge | (tick & (&st_ff.stepCnt));

  assign targetDuty = analogMode ? scaleDuty(st_ff.dutyMeas, analogLevelCode)
                                 : st_ff.dutyMeas;

  assign divTrial = {st_ff.divRem[`LDP_CNT_W-1:0], 1'b0};

  // each channel compares the step count shifted back by its phase offset
  genvar ch;
  generate
    for (ch = 0; ch < `LDP_NUM_CH; ch++) begin : g_chan
      logic [`LDP_STEP_W-1:0] offset;
      logic [`LDP_STEP_W-1:0] phase;
      assign offset = phaseOffset(ch, psSync);
      assign phase  = st_ff.stepCnt - offset;
      assign chanOn[ch] = ({1'b0, phase} < st_ff.effDuty);
    end
  endgenerate

  assign ctrlWord = {30'h0000_0000, st_ff.ctrlFrameLock, st_ff.ctrlEnable};
  assign merged   = laneMerge(regValue, writedata, byteenable);

  always_comb begin
    regValue = 32'h0000_0000;
    case (wordIdx)
      `LDP_REG_CTRL:   regValue = ctrlWord;
      `LDP_REG_PERIOD: regValue = {16'h0000, st_ff.periodReg};
      `LDP_REG_FRAME:  regValue = {29'h0000_0000, st_ff.frameShift};
      `LDP_REG_STATUS: begin
        regValue[`LDP_DUTY_W-1:0] = st_ff.dutyMeas;
        regValue[`LDP_ST_DIRECT]  = direct;
        regValue[`LDP_ST_ANALOG]  = analogMode;
        regValue[`LDP_ST_LEVEL]   = st_ff.levelOut;
        regValue[`LDP_ST_PSHIFT]  = psSync & ~direct;
        regValue[`LDP_ST_VALID]   = st_ff.measValid;
        regValue[31:24]           = analogLevelCode;
      end
      default:         regValue = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.pwmPrev = pwmSync;
    nxt_st.frmPrev = frmSync;

    // duty measurement: high time over period, rising edge to rising edge
    if (pwmRise) begin
      // the rising cycle is already high and counts as the first high cycle
      nxt_st.highCnt = `LDP_CNT_W'(1);
      nxt_st.perCnt  = `LDP_CNT_W'(1);
      if (st_ff.meas == ldp_pkg::MEAS_IDLE && st_ff.perCnt != '0
          && st_ff.perCnt != `LDP_CNT_MAX) begin
        nxt_st.meas    = ldp_pkg::MEAS_DIV;
        nxt_st.divRem  = {1'b0, st_ff.highCnt};
        nxt_st.divDen  = st_ff.perCnt;
        nxt_st.divQ    = '0;
        nxt_st.divBits = '0;
      end
    end else begin
      if (st_ff.perCnt != `LDP_CNT_MAX) begin
        nxt_st.perCnt = st_ff.perCnt + `LDP_CNT_W'(1);
      end
      if (pwmSync && st_ff.highCnt != `LDP_CNT_MAX) begin
        nxt_st.highCnt = st_ff.highCnt + `LDP_CNT_W'(1);
      end
    end

    // a static input has no edges: it reads as 0% or 100% after timeout
    if (st_ff.perCnt == `LDP_CNT_MAX) begin
      nxt_st.dutyMeas  = pwmSync ? `LDP_DUTY_FULL : '0;
      nxt_st.measValid = 1'b1;
    end

    // restoring division gives ten fraction bits, one per cycle
    case (st_ff.meas)
      ldp_pkg::MEAS_IDLE: begin
        nxt_st.divBits = '0;
      end
      ldp_pkg::MEAS_DIV: begin
        if (divTrial >= {1'b0, st_ff.divDen}) begin
          nxt_st.divRem = divTrial - {1'b0, st_ff.divDen};
          nxt_st.divQ   = {st_ff.divQ[`LDP_STEP_W-2:0], 1'b1};
        end else begin
          nxt_st.divRem = divTrial;
          nxt_st.divQ   = {st_ff.divQ[`LDP_STEP_W-2:0], 1'b0};
        end
        nxt_st.divBits = st_ff.divBits + 4'h1;
        if (st_ff.divBits == `LDP_DIV_STEPS - 4'h1) begin
          nxt_st.meas      = ldp_pkg::MEAS_IDLE;
          nxt_st.dutyMeas  = {1'b0, nxt_st.divQ};
          nxt_st.measValid = 1'b1;
        end
      end
      default: begin
        nxt_st.meas = ldp_pkg::MEAS_IDLE;
      end
    endcase

    // frame length is measured between synchronised frame edges
    if (frmSync && !st_ff.frmPrev) begin
      nxt_st.frameLen = st_ff.frameCnt;
      nxt_st.frameCnt = '0;
    end else if (st_ff.frameCnt != `LDP_CNT_MAX) begin
      nxt_st.frameCnt = st_ff.frameCnt + `LDP_CNT_W'(1);
    end

    // step generator; a frame edge realigns phase to the frame
    if (frameEdge) begin
      nxt_st.preCnt  = '0;
      nxt_st.stepCnt = '0;
    end else if (tick) begin
      nxt_st.preCnt  = '0;
      nxt_st.stepCnt = st_ff.stepCnt + `LDP_STEP_W'(1);
    end else begin
      nxt_st.preCnt  = st_ff.preCnt + 16'h0001;
    end

    // duty and current level change only on a period boundary
    if (periodStart) begin
      nxt_st.effDuty  = targetDuty;
      nxt_st.levelSel = cselSync;
    end

    // output stage
    if (!st_ff.ctrlEnable) begin
      nxt_st.gate     = '0;
      nxt_st.levelOut = cselSync;
    end else if (direct) begin
      nxt_st.gate     = {`LDP_NUM_CH{pwmSync}};
      nxt_st.levelOut = cselSync;
    end else begin
      nxt_st.gate     = chanOn;
      nxt_st.levelOut = st_ff.levelSel;
    end

    // bus: one wait state; a write lands on the waited edge, and ack keeps the
    // master's held cycle at the taken edge from being taken as a second write
    nxt_st.ack = (read | write) & ~st_ff.ack;
    if ((read | write) && !st_ff.ack) begin
      nxt_st.rdata = read ? regValue : 32'h0000_0000;
      if (write) begin
        case (wordIdx)
          `LDP_REG_CTRL: begin
            nxt_st.ctrlEnable    = merged[`LDP_CTRL_ENABLE];
            nxt_st.ctrlFrameLock = merged[`LDP_CTRL_FLOCK];
          end
          `LDP_REG_PERIOD: nxt_st.periodReg  = merged[15:0];
          `LDP_REG_FRAME:  nxt_st.frameShift = merged[2:0];
          default:         nxt_st.rdata      = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_ff               <= '0;
      st_ff.meas          <= ldp_pkg::MEAS_IDLE;
      st_ff.ctrlEnable    <= `LDP_RST_ENABLE;
      st_ff.ctrlFrameLock <= `LDP_RST_FLOCK;
      st_ff.periodReg     <= `LDP_RST_PERIOD;
      st_ff.frameShift    <= `LDP_RST_FSHIFT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign waitrequest         = (read | write) & ~st_ff.ack;
  assign readdata            = st_ff.rdata;
  assign channelGate         = st_ff.gate;
  assign currentSetSecondary = st_ff.levelOut;

endmodule // ldp_dimming

`default_nettype wire

// ==== test/ldp_pin_source.sv ====
/*
  Far-side pin source: the controller's PWM on the dimming input and a frame
  pulse of one cycle.
  Assumes the bench changes the settings only between measurements.
*/
`default_nettype none

module ldp_pin_source (
  // clock
  input  wire logic        sys_clk,
  // waveform settings in clock cycles, frame period 0 keeps the pulse off
  input  wire logic [15:0] pwmPeriod,
  input  wire logic [15:0] pwmHigh,
  input  wire logic [15:0] framePeriod,
  // pins toward the controller
  output logic             dimming_pwm_input,
  output logic             frame_sync_input
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] pwmCnt = 16'h0000;
  logic [15:0] frmCnt = 16'h0000;

  initial begin
    dimming_pwm_input = 1'b0;
    frame_sync_input  = 1'b0;
  end

  always @(posedge sys_clk) begin
    pwmCnt <= (pwmCnt + 16'h0001 >= pwmPeriod) ? 16'h0000 : pwmCnt + 16'h0001;
    // the duty rides on the input; a high time of a full period or more holds
    // it high, leaving the analog code alone to set the duty
    dimming_pwm_input <= pwmCnt < pwmHigh;
    frmCnt <= (frmCnt + 16'h0001 >= framePeriod) ? 16'h0000 : frmCnt + 16'h0001;
    frame_sync_input <= framePeriod != 16'h0000 && frmCnt == 16'h0000;
  end
endmodule // ldp_pin_source

`default_nettype wire

// ==== test/ldp_dimming_chk.sv ====
/*
  Port checker of ldp_dimming, bound to every instance.
  Assumes one clock and an asynchronous active-high reset.
*/
`default_nettype none

module ldp_dimming_chk (
  // clock, reset and bus
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // pins
  input wire logic        dimming_pwm_input,
  input wire logic        current_level_select,
  input wire logic        phase_shift_enable,
  input wire logic        directModeStrap,
  input wire logic [3:0]  channelGate,
  input wire logic        currentSetSecondary
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // enable copy lags the design by a cycle, so it only gates long windows
  logic       enFf;
  logic [2:0] dirCnt;
  logic [2:0] psLowCnt;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      enFf     <= 1'b0;
      dirCnt   <= 3'h0;
      psLowCnt <= 3'h0;
    end else begin
      if (write && !waitrequest && address == 4'h0 && byteenable[0]) begin
        enFf <= writedata[0];
      end
      dirCnt   <= !directModeStrap ? 3'h0 : (dirCnt == 3'h7 ? dirCnt : dirCnt + 3'h1);
      psLowCnt <= phase_shift_enable ? 3'h0 : (psLowCnt == 3'h7 ? psLowCnt : psLowCnt + 3'h1);
    end
  end

  wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request waited more than one cycle");
  idle_nowait_a: assert property (!read && !write |-> !waitrequest)
    else $error("waitrequest high without a request");
  dir_copy_a: assert property (
    dirCnt == 3'h7 && enFf && $past(enFf, 4)
    |-> channelGate == {4{$past(dimming_pwm_input, 3)}}) else $error("direct gate not a copy");
  dir_level_a: assert property (
    dirCnt == 3'h7 |-> currentSetSecondary == $past(current_level_select, 3))
    else $error("direct current level wrong");
  gang_gate_a: assert property (
    psLowCnt == 3'h7 |-> channelGate == 4'h0 || channelGate == 4'hF)
    else $error("channels differ without phase shift");
  off_dark_a: assert property (!enFf && !$past(enFf) |-> channelGate == 4'h0)
    else $error("gate on while disabled");
  unmap_zero_a: assert property (
    read && !waitrequest && !(address inside {4'h0, 4'h4, 4'h8, 4'hC})
    |-> readdata == 32'h0000_0000) else $error("unmapped read not zero");
  stat_direct_a: assert property (
    read && !waitrequest && address == 4'hC && dirCnt == 3'h7 |-> readdata[16])
    else $error("status misses direct mode");

  dir_on_c:   cover property (dirCnt == 3'h7 && channelGate == 4'hF);
  ps_split_c: cover property (!directModeStrap && channelGate == 4'h9);
  unmap_rd_c: cover property (read && !waitrequest && address == 4'h2);
endmodule // ldp_dimming_chk

bind ldp_dimming ldp_dimming_chk chk (
  .sys_clk, .reset, .address, .read, .write, .writedata, .byteenable, .readdata,
  .waitrequest, .dimming_pwm_input, .current_level_select, .phase_shift_enable,
  .directModeStrap, .channelGate, .currentSetSecondary
);

`default_nettype wire

// ==== test/ldp_dimming_tb.sv ====
/*
  Self-checking bench of ldp_dimming: registers, measured and scaled duty,
  phase shift, level select timing, frame lock and direct mode.
  Assumes ldp_pin_source drives the dimming and frame pins.
*/
`default_nettype none

module ldp_dimming_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk;
  logic        reset      = 1'b1;
  logic        read       = 1'b0;
  logic        write      = 1'b0;
  logic [3:0]  address    = 4'h0;
  logic [3:0]  byteenable = 4'h0;
  logic [31:0] writedata  = 32'h0000_0000;
  logic        sel        = 1'b0;
  logic        anEn       = 1'b0;
  logic        psEn       = 1'b0;
  logic        strap      = 1'b0;
  logic [7:0]  code       = 8'h00;
  logic [15:0] pwmPer     = 16'h0190;
  logic [15:0] pwmHi      = 16'h00C8;
  logic [15:0] frmPer     = 16'h0000;
  logic [31:0] readdata, rd;
  logic [3:0]  channelGate;
  logic [2:0]  hist, selH;
  logic        waitrequest, currentSetSecondary, pwm, frm;
  int          failures   = 0;
  int          testsRun   = 0;
  int          seed       = 32'h0000_0a1e;
  int          hi, n, d, agree;
  int          ones[4];

  ldp_dimming uut (
    .sys_clk, .reset, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .dimming_pwm_input(pwm), .current_level_select(sel),
    .analog_dimming_enable(anEn), .phase_shift_enable(psEn), .frame_sync_input(frm),
    .directModeStrap(strap), .analogLevelCode(code), .channelGate, .currentSetSecondary
  );
  ldp_pin_source src (
    .sys_clk, .pwmPeriod(pwmPer), .pwmHigh(pwmHi), .framePeriod(frmPer),
    .dimming_pwm_input(pwm), .frame_sync_input(frm)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    if (failures == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one request, held until the slave stops waiting
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] dat,
                     input logic [3:0] be, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge sys_clk);
    address    <= adr;
    writedata  <= dat;
    byteenable <= be;
    read       <= !wr;
    write      <= wr;
    do begin
      @(posedge sys_clk);
      k++;
    end while (waitrequest && k < 50);
    if (k >= 50) begin
      failures++;
      report_and_stop();
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  // 1024 cycles is one whole dimming period with one-cycle steps
  task automatic sweep();
    ones  = '{0, 0, 0, 0};
    agree = 0;
    repeat (1024) begin
      @(negedge sys_clk);
      for (int k = 0; k < 4; k++) ones[k] += int'(channelGate[k]);
      agree += int'(channelGate[0] == channelGate[2]);
    end
  endtask

  function automatic int exp_duty(input int h, input bit an, input int c);
    int v;
    v = 1024 * h / 400;
    if (an) v = v * (c + c / 128) / 256;
    return v;
  endfunction

  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    bus(1'b0, 4'h0, 32'h0000_0000, 4'h0, rd);
    check("ctrl reset", rd, 32'h0000_0000);
    bus(1'b0, 4'h4, 32'h0000_0000, 4'h0, rd);
    check("period reset", rd, 32'h0000_0061);
    bus(1'b0, 4'h8, 32'h0000_0000, 4'h0, rd);
    check("frame reset", rd, 32'h0000_0000);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF, 4'hF, rd);
    bus(1'b1, 4'h4, 32'h0000_1234, 4'h1, rd);
    bus(1'b0, 4'h4, 32'h0000_0000, 4'h0, rd);
    check("period lane", rd, 32'h0000_0034);
    bus(1'b0, 4'h2, 32'h0000_0000, 4'h0, rd);
    check("unmapped read", rd, 32'h0000_0000);
    check("dark gates", 32'(channelGate), 32'h0000_0000);
    bus(1'b1, 4'h4, 32'h0000_0000, 4'hF, rd);
    bus(1'b1, 4'h0, 32'h0000_0001, 4'hF, rd);
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      hi = (i >= 4) ? 200 : 1 + int'($unsigned($random(seed)) % 399);
      code  <= (i == 1) ? 8'hFF : (i == 3) ? 8'h00 : (i == 5) ? 8'h80 : 8'($random(seed));
      anEn  <= i inside {1, 2, 3, 5};
      psEn  <= i >= 4;
      pwmHi <= 16'(hi);
      repeat (4000) @(posedge sys_clk);
      sweep();
      d = exp_duty(hi, i inside {1, 2, 3, 5}, int'(code));
      for (int k = 0; k < 4; k++) check("channel duty", ones[k], d);
      if (i < 4) check("ganged", agree, 1024);
      if (i == 4) check("phase split", agree, 0);
    end
    @(posedge sys_clk);
    psEn <= 1'b0;
    anEn <= 1'b0;
    repeat (3000) @(posedge sys_clk);
    wait_gate(1'b1);
    wait_gate(1'b0);
    @(posedge sys_clk);
    sel <= 1'b1;
    repeat (600) begin
      @(negedge sys_clk);
      if (!channelGate[0]) check("level held", 32'(currentSetSecondary), 32'h0000_0000);
    end
    check("level applied", 32'(currentSetSecondary), 32'h0000_0001);
    frmPer <= 16'h0800;
    bus(1'b1, 4'h0, 32'h0000_0003, 4'hF, rd);
    repeat (10000) @(posedge sys_clk);
    for (int f = 0; f < 3; f++) begin
      n = 0;
      do begin
        d = int'(channelGate[0]);
        @(negedge sys_clk);
        n++;
      end while (!frm && n < 4096);
      if (n >= 4096) failures++;
      if (n >= 4096) report_and_stop();
      check("before frame", d, 0);
      repeat (8) @(negedge sys_clk);
      check("after frame", 32'(channelGate[0]), 32'h0000_0001);
    end
    @(posedge sys_clk);
    strap  <= 1'b1;
    pwmPer <= 16'h0007;
    pwmHi  <= 16'h0003;
    for (int k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      sel <= 1'($random(seed));
      @(negedge sys_clk);
      if (k > 8) check("direct gate", 32'(channelGate), 32'({4{hist[2]}}));
      if (k > 8) check("direct level", 32'(currentSetSecondary), 32'(selH[2]));
      hist = {hist[1:0], pwm};
      selH = {selH[1:0], sel};
    end
    bus(1'b0, 4'hC, 32'h0000_0000, 4'h0, rd);
    check("status direct", 32'(rd[16]), 32'h0000_0001);
    report_and_stop();
  end

  task automatic wait_gate(input logic v);
    n = 0;
    while (channelGate[0] !== v && n < 4096) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 4096) begin
      failures++;
      report_and_stop();
    end
  endtask
endmodule // ldp_dimming_tb

`default_nettype wire
